//--- rtl/timer_split_regs.svh
// Summary of operation
// [RULE1] Split mode bit set runs two independent 8-bit auto-reload counters
// [RULE2] In split mode each byte counter reloads from its own reload register
// [RULE3] In split mode run control starts and stops only the high byte
// [RULE4] In split mode the low byte counts regardless of run control
// [RULE5] High byte: system_clock if its select bit set, else ext clock select field
// [RULE6] Low byte picks its clock independently with the same encoding
// [RULE7] Each byte rolling 0xFF to 0x00 sets its own overflow flag
// [RULE8] Timer interrupt enabled: every high byte overflow requests an interrupt
// [RULE9] With low interrupt enable set too, either byte overflow requests one
// [RULE10] Software reads both flags to find the interrupt source
// [RULE11] Hardware never clears overflow flags; software clears them
// [RULE12] Writing 1 to capture enable selects oscillator capture mode
// [RULE13] Software keeps split mode at 0 while capture mode is on
// [RULE14] Capture event on each rtc rising edge, or every 8 ext oscillator cycles
// [RULE15] Capture copies 16-bit count to reload registers and sets high flag
// [RULE16] Software uses a fast timer clock and differences successive captures
// [RULE17] Split mode clear runs one 16-bit counter auto-reloading from both reloads; code wraps to 0x0000 without reload while capture enable is set
// [RULE18] In 16-bit mode rollover 0xFFFF to 0x0000 sets the high flag
// [RULE19] Low flag is set on every low byte overflow in any mode
// [RULE20] Slow oscillator ticks are synchronised into one-cycle count enables
`ifndef TIMER_SPLIT_REGS_SVH
`define TIMER_SPLIT_REGS_SVH

// ----------------------------------------
// Register addresses on the special function space
// ----------------------------------------
`define ADDR_SPLIT_CONTROL 8'h91
`define ADDR_RELOAD_LOW 8'h92
`define ADDR_RELOAD_HIGH 8'h93
`define ADDR_COUNT_LOW 8'h94
`define ADDR_COUNT_HIGH 8'h95

// ----------------------------------------
// Reset values and field codes
// ----------------------------------------
`define RESET_BYTE 8'h00
`define EXT_SEL_DIV12 2'h0
`define EXT_SEL_RTC 2'h1
`define EXT_SEL_EXT_DIV8 2'h3
`define BYTE_ALL_ONES 8'hFF

// ----------------------------------------
// Divider counts
// ----------------------------------------
`define SYSTEM_CLOCK_DIV 12
`define DIV12_LAST 4'hB
`define EXT_DIV_LAST 3'h7

`endif

//--- rtl/timer_split_pkg.sv
package timer_split_pkg;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_irq_enable;
    logic capture_enable;
    logic split_mode_select;
    logic high_run_control;
    logic [1:0] ext_clock_select;
  } split_control_t;

  // One cycle of special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_t;

endpackage

//--- rtl/timer_split_reload_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_split_regs.svh"

module timer_split_reload_capture
  import timer_split_pkg::*;
(
  input wire logic CLK, // System clock, 125 MHz
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic [7:0] SFR_ADDR, // Register address
  input wire logic [7:0] SFR_WDATA, // Write data
  input wire logic SFR_WR, // Write strobe, one cycle
  input wire logic SFR_RD, // Read strobe, one cycle
  input wire logic HIGH_SYSTEM_CLOCK_SELECT, // High byte uses system clock
  input wire logic LOW_SYSTEM_CLOCK_SELECT, // Low byte (and 16-bit timer) uses system clock
  input wire logic TIMER_IRQ_ENABLE, // Timer interrupt enable
  input wire logic RTC_OSC, // Real-time oscillator, asynchronous
  input wire logic EXT_OSC, // External oscillator, asynchronous
  output logic [7:0] SFR_RDATA, // Read data, valid the cycle after SFR_RD
  output logic IRQ // Interrupt request, level
);

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  function automatic logic pick_tick(input logic sys_sel, input logic [1:0] ext_sel,
                                     input logic div12, input logic rtc, input logic ext8);
    logic t;
    t = 1'b0;
    if (sys_sel)
      t = 1'b1;
    else if (ext_sel == `EXT_SEL_DIV12)
      t = div12;
    else if (ext_sel == `EXT_SEL_RTC)
      t = rtc;
    else if (ext_sel == `EXT_SEL_EXT_DIV8)
      t = ext8;
    return t;
  endfunction

  sfr_req_t req;
  split_control_t ctrl_q;
  logic [7:0] reload_low_q;
  logic [7:0] reload_high_q;
  logic [7:0] count_low_q;
  logic [7:0] count_high_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic [2:0] rtc_sync_q;
  logic [2:0] ext_sync_q;
  logic [3:0] div12_q;
  logic [2:0] ext_div_q;
  logic div12_tick;
  logic rtc_tick;
  logic ext_tick;
  logic ext8_tick;
  logic low_tick;
  logic high_tick;
  logic wide_tick;
  logic low_roll;
  logic high_roll;
  logic wide_roll;
  logic capture_event;
  logic set_high_flag;
  logic set_low_flag;
  logic wr_ctrl;
  logic wr_rl;
  logic wr_rh;
  logic wr_cl;
  logic wr_ch;

  assign req = '{addr: SFR_ADDR, wdata: SFR_WDATA, wr: SFR_WR, rd: SFR_RD};

  // ----------------------------------------
  // Oscillator synchronisers and tick generation
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rtc_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
    end
    else
    begin
      rtc_sync_q <= {rtc_sync_q[1:0], RTC_OSC}; // RULE20
      ext_sync_q <= {ext_sync_q[1:0], EXT_OSC}; // RULE20
    end
  end

  // Edge detect looks only at the second and third stages
  assign rtc_tick = rtc_sync_q[1] & ~rtc_sync_q[2]; // RULE20
  assign ext_tick = ext_sync_q[1] & ~ext_sync_q[2]; // RULE20

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      div12_q <= 4'h0;
    else if (div12_q == `DIV12_LAST)
      div12_q <= 4'h0;
    else
      div12_q <= div12_q + 4'h1;
  end

  assign div12_tick = (div12_q == `DIV12_LAST);

  // External oscillator divided by eight
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ext_div_q <= 3'h0;
    else if (ext_tick)
      ext_div_q <= ext_div_q + 3'h1;
  end

  assign ext8_tick = ext_tick && (ext_div_q == `EXT_DIV_LAST);

  assign high_tick = pick_tick(HIGH_SYSTEM_CLOCK_SELECT, ctrl_q.ext_clock_select, div12_tick,
                               rtc_tick, ext8_tick); // RULE5
  assign low_tick = pick_tick(LOW_SYSTEM_CLOCK_SELECT, ctrl_q.ext_clock_select, div12_tick,
                              rtc_tick, ext8_tick); // RULE6
  assign wide_tick = low_tick && ctrl_q.high_run_control;

  // ----------------------------------------
  // Overflow and capture events
  // ----------------------------------------
  assign low_roll = ctrl_q.split_mode_select ? low_tick && (count_low_q == `BYTE_ALL_ONES)
                  : wide_tick && (count_low_q == `BYTE_ALL_ONES); // RULE19
  assign high_roll = ctrl_q.split_mode_select && ctrl_q.high_run_control && high_tick
                     && (count_high_q == `BYTE_ALL_ONES); // RULE3
  assign wide_roll = !ctrl_q.split_mode_select && wide_tick
                     && ({count_high_q, count_low_q} == {`BYTE_ALL_ONES, `BYTE_ALL_ONES});
  assign capture_event = ctrl_q.capture_enable
                         && (ctrl_q.ext_clock_select[1] ? ext8_tick : rtc_tick); // RULE14
  assign set_high_flag = high_roll || wide_roll || capture_event; // RULE7 RULE18 RULE15
  assign set_low_flag = low_roll; // RULE7 RULE19

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign wr_ctrl = req.wr && (req.addr == `ADDR_SPLIT_CONTROL);
  assign wr_rl = req.wr && (req.addr == `ADDR_RELOAD_LOW);
  assign wr_rh = req.wr && (req.addr == `ADDR_RELOAD_HIGH);
  assign wr_cl = req.wr && (req.addr == `ADDR_COUNT_LOW);
  assign wr_ch = req.wr && (req.addr == `ADDR_COUNT_HIGH);

  // Control register; hardware flag set wins over a software clear
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ctrl_q <= split_control_t'(`RESET_BYTE);
    else
    begin
      if (wr_ctrl)
        ctrl_q <= split_control_t'(req.wdata); // RULE12
      if (set_high_flag)
        ctrl_q.high_overflow_flag <= 1'b1; // RULE11
      if (set_low_flag)
        ctrl_q.low_overflow_flag <= 1'b1; // RULE11
    end
  end

  // Reload registers; a capture overrides a software write in the same cycle
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      reload_low_q <= `RESET_BYTE;
      reload_high_q <= `RESET_BYTE;
    end
    else if (capture_event)
    begin
      reload_low_q <= count_low_q; // RULE15
      reload_high_q <= count_high_q; // RULE15
    end
    else
    begin
      if (wr_rl)
        reload_low_q <= req.wdata;
      if (wr_rh)
        reload_high_q <= req.wdata;
    end
  end

  // ----------------------------------------
  // Counters; a software write takes priority over counting
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      count_low_q <= `RESET_BYTE;
    else if (wr_cl)
      count_low_q <= req.wdata;
    else if (ctrl_q.split_mode_select)
    begin
      if (low_roll)
        count_low_q <= reload_low_q; // RULE1 RULE2
      else if (low_tick)
        count_low_q <= count_low_q + 8'h01; // RULE4
    end
    else if (wide_roll && !ctrl_q.capture_enable)
      count_low_q <= reload_low_q; // RULE17
    else if (wide_tick)
      count_low_q <= count_low_q + 8'h01; // RULE17
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      count_high_q <= `RESET_BYTE;
    else if (wr_ch)
      count_high_q <= req.wdata;
    else if (ctrl_q.split_mode_select)
    begin
      if (high_roll)
        count_high_q <= reload_high_q; // RULE1 RULE2
      else if (ctrl_q.high_run_control && high_tick)
        count_high_q <= count_high_q + 8'h01; // RULE3
    end
    else if (wide_roll && !ctrl_q.capture_enable)
      count_high_q <= reload_high_q; // RULE17
    else if (wide_tick && (count_low_q == `BYTE_ALL_ONES))
      count_high_q <= count_high_q + 8'h01; // RULE17
  end

  // ----------------------------------------
  // Read data and interrupt request
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      rdata_q <= `RESET_BYTE;
    else if (req.rd)
    begin
      if (req.addr == `ADDR_SPLIT_CONTROL)
        rdata_q <= ctrl_q;
      else if (req.addr == `ADDR_RELOAD_LOW)
        rdata_q <= reload_low_q;
      else if (req.addr == `ADDR_RELOAD_HIGH)
        rdata_q <= reload_high_q;
      else if (req.addr == `ADDR_COUNT_LOW)
        rdata_q <= count_low_q;
      else if (req.addr == `ADDR_COUNT_HIGH)
        rdata_q <= count_high_q;
      else
        rdata_q <= `RESET_BYTE;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      irq_q <= 1'b0;
    else
      irq_q <= TIMER_IRQ_ENABLE && (ctrl_q.high_overflow_flag
               || (ctrl_q.low_irq_enable && ctrl_q.low_overflow_flag)); // RULE8 RULE9
  end

  assign SFR_RDATA = rdata_q;
  assign IRQ = irq_q;

endmodule // timer_split_reload_capture

`default_nettype wire

//--- tb/timer_split_sva.sv
`timescale 1ns/1ps
`default_nettype none
module timer_split_sva
  import timer_split_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RSTN, // Reset
  input wire logic [7:0] SFR_ADDR, // Address
  input wire logic [7:0] SFR_WDATA, // Write data
  input wire logic SFR_WR, // Write
  input wire logic SFR_RD, // Read
  input wire logic HIGH_SYSTEM_CLOCK_SELECT, // High clock
  input wire logic LOW_SYSTEM_CLOCK_SELECT, // Low clock
  input wire logic TIMER_IRQ_ENABLE, // Enable
  input wire logic RTC_OSC, // Rtc
  input wire logic EXT_OSC, // Ext
  input wire logic [7:0] SFR_RDATA, // Read data
  input wire logic IRQ // Interrupt
);
  // ---
  // Mode bits as last written
  // ---
  logic split_q, cap_q;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      {cap_q, split_q} <= 2'h0;
    else if (SFR_WR && SFR_ADDR == 8'h91)
      {cap_q, split_q} <= SFR_WDATA[4:3];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_RDATA_HOLD:
    assert property (!$past(SFR_RD) |-> $stable(SFR_RDATA)) else $error("read data moved");
  AST_UNMAPPED_READ:
    assert property (SFR_RD && (SFR_ADDR < 8'h91 || SFR_ADDR > 8'h95) |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_RESET_QUIET:
    assert property ($rose(RSTN) |-> !IRQ && SFR_RDATA == 8'h00) else $error("dirty reset");
  AST_IRQ_NEEDS_ENABLE:
    assert property (IRQ |-> $past(TIMER_IRQ_ENABLE)) else $error("irq while disabled");
  AST_IRQ_HOLDS:
    assert property (IRQ && TIMER_IRQ_ENABLE && !$past(SFR_WR) |=> IRQ) else $error("irq dropped");
  AST_CTRL_READBACK:
    assert property (SFR_WR && SFR_ADDR == 8'h91 ##1 !SFR_WR ##1 SFR_RD && SFR_ADDR == 8'h91
      |=> SFR_RDATA[5:0] == $past(SFR_WDATA[5:0], 3)) else $error("control readback");
  AST_RELOAD_READBACK:
    assert property (SFR_WR && SFR_ADDR[7:1] == 7'h49 && !cap_q ##1 !SFR_WR && !cap_q
      ##1 SFR_RD && SFR_ADDR == $past(SFR_ADDR, 2) && !cap_q
      |=> SFR_RDATA == $past(SFR_WDATA, 3)) else $error("reload readback");
  AST_SPLIT_LOW_COUNTS:
    assert property (SFR_RD && SFR_ADDR == 8'h94 && !SFR_WR && split_q && !cap_q
      && LOW_SYSTEM_CLOCK_SELECT ##1 SFR_RD && SFR_ADDR == 8'h94 && !SFR_WR
      |=> SFR_RDATA == $past(SFR_RDATA) + 8'h01 || $past(SFR_RDATA) == 8'hFF)
    else $error("low byte not counting");
  cover property ($rose(IRQ));
  cover property (SFR_RD && SFR_ADDR == 8'h91);
  cover property (SFR_RD ##1 SFR_RD);
endmodule // timer_split_sva
bind timer_split_reload_capture timer_split_sva u_sva (.CLK(CLK), .RSTN(RSTN),
  .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .HIGH_SYSTEM_CLOCK_SELECT(HIGH_SYSTEM_CLOCK_SELECT), .LOW_SYSTEM_CLOCK_SELECT(LOW_SYSTEM_CLOCK_SELECT),
  .TIMER_IRQ_ENABLE(TIMER_IRQ_ENABLE), .RTC_OSC(RTC_OSC), .EXT_OSC(EXT_OSC),
  .SFR_RDATA(SFR_RDATA), .IRQ(IRQ));
`default_nettype wire

//--- tb/tb_timer_split_reload_capture.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_split_reload_capture
  import timer_split_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  row_t rows [7] = '{'{8'h92, 8'hA5, 8'hA5}, '{8'h93, 8'h5A, 8'h5A}, '{8'h91, 8'h20, 8'h20},
    '{8'h94, 8'h3C, 8'h3C}, '{8'h95, 8'hC3, 8'hC3}, '{8'h90, 8'h77, 8'h00},
    '{8'h96, 8'h11, 8'h00}};
  logic CLK = 1'b0, RSTN = 1'b0, SFR_WR = 1'b0, SFR_RD = 1'b0, RTC_OSC = 1'b0, EXT_OSC = 1'b0;
  logic HIGH_SYSTEM_CLOCK_SELECT = 1'b0, LOW_SYSTEM_CLOCK_SELECT = 1'b0, TIMER_IRQ_ENABLE = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, d, d1, l1, h1, l2, h2;
  logic [15:0] p;
  logic IRQ;
  int n_mismatch = 0, checked = 0, cycles = 0;
  timer_split_reload_capture DUT (.CLK(CLK), .RSTN(RSTN), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .HIGH_SYSTEM_CLOCK_SELECT(HIGH_SYSTEM_CLOCK_SELECT), .LOW_SYSTEM_CLOCK_SELECT(LOW_SYSTEM_CLOCK_SELECT),
    .TIMER_IRQ_ENABLE(TIMER_IRQ_ENABLE), .RTC_OSC(RTC_OSC), .EXT_OSC(EXT_OSC),
    .SFR_RDATA(SFR_RDATA), .IRQ(IRQ));
  initial forever #4 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ---
  // Tasks, all entered just after a rising edge
  // ---
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    SFR_ADDR = a;
    SFR_WDATA = w;
    SFR_WR = 1'b1;
    tick(1);
    SFR_WR = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    tick(1);
    SFR_RD = 1'b0;
    r = SFR_RDATA;
    tick(1);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reset_check();
    RSTN = 1'b0;
    tick(8);
    RSTN = 1'b1;
    for (int a = 8'h91; a < 8'h96; a++)
    begin
      rd(a[7:0], d);
      check(d, 8'h00);
    end
  endtask
  // ---
  // Scenarios
  // ---
  initial
  begin
    reset_check();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      check(d, rows[i].e);
    end
    {HIGH_SYSTEM_CLOCK_SELECT, LOW_SYSTEM_CLOCK_SELECT, TIMER_IRQ_ENABLE} = 3'h7;
    wr(8'h94, 8'hF0);
    wr(8'h95, 8'h77);
    wr(8'h92, 8'h10);
    wr(8'h91, 8'h08);
    tick(30);
    SFR_ADDR = 8'h94;
    SFR_RD = 1'b1;
    tick(1);
    d = SFR_RDATA;
    tick(1);
    SFR_RD = 1'b0;
    d1 = SFR_RDATA;
    tick(1);
    check(d1, d == 8'hFF ? 8'h10 : d + 8'h01);
    rd(8'h95, d);
    check(d, 8'h77);
    rd(8'h91, d);
    check(d, 8'h48);
    check({7'h00, IRQ}, 8'h00);
    wr(8'h91, 8'h28);
    tick(260);
    check({7'h00, IRQ}, 8'h01);
    rd(8'h91, d);
    check(d, 8'h68);
    wr(8'h95, 8'hFE);
    wr(8'h91, 8'h0C);
    tick(10);
    rd(8'h91, d);
    check(d & 8'hBF, 8'h8C);
    check({7'h00, IRQ}, 8'h01);
    TIMER_IRQ_ENABLE = 1'b0;
    tick(2);
    check({7'h00, IRQ}, 8'h00);
    wr(8'h91, 8'h00);
    wr(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    wr(8'h94, 8'hFE);
    wr(8'h95, 8'hFF);
    wr(8'h91, 8'h04);
    tick(10);
    rd(8'h91, d);
    check(d, 8'hC4);
    rd(8'h95, d);
    check(d, 8'h12);
    wr(8'h91, 8'h15);
    RTC_OSC = 1'b1;
    tick(10);
    rd(8'h92, l1);
    rd(8'h93, h1);
    RTC_OSC = 1'b0;
    tick(86);
    RTC_OSC = 1'b1;
    tick(10);
    rd(8'h92, l2);
    rd(8'h93, h2);
    RTC_OSC = 1'b0;
    p = {h2, l2} - {h1, l1};
    check(p[15:8], 8'h00);
    check(p[7:0], 8'h64);
    rd(8'h91, d);
    check(d & 8'hBF, 8'h95);
    wr(8'h91, 8'h17);
    for (int i = 0; i < 8; i++)
    begin
      EXT_OSC = 1'b1;
      tick(4);
      EXT_OSC = 1'b0;
      tick(4);
      rd(8'h91, d);
      check(d & 8'h80, i == 7 ? 8'h80 : 8'h00);
    end
    // Low byte on system clock, high byte on the divide-by-twelve tick
    {HIGH_SYSTEM_CLOCK_SELECT, LOW_SYSTEM_CLOCK_SELECT} = 2'h1;
    wr(8'h91, 8'h0C);
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    rd(8'h94, l1);
    rd(8'h95, h1);
    tick(8);
    rd(8'h94, l2);
    rd(8'h95, h2);
    check(l2 - l1, 8'h0C);
    check(h2 - h1, 8'h01);
    // Reserved select gives the high byte no ticks
    wr(8'h91, 8'h0E);
    rd(8'h95, h1);
    tick(10);
    rd(8'h95, h2);
    check(h2 - h1, 8'h00);
    reset_check();
    print_verdict();
  end
endmodule // tb_timer_split_reload_capture
`default_nettype wire
